/* bench/clk_net_monitor.sv */
// checker of the clock network and synthesizer outputs
`timescale 1ns/10ps
module clk_net_monitor (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_config_active,
    input wire i_synth_reset_n,
    input wire o_hreadyout,
    input wire o_hresp,
    input wire o_global_high_impedance,
    input wire o_global_reset,
    input wire [7:0] o_pin_gpio_free,
    input wire o_synth_out_global_net,
    input wire o_synth_out_fabric,
    input wire o_synth_lock,
    input wire [7:0] o_global_buffer,
    input wire [7:0] o_blk_clock,
    input wire [3:0] o_blk_set_reset,
    input wire [3:0] o_blk_clk_enable
);
    localparam int LOCK_MIN = 1248;
    logic [11:0] lock_age;
    logic [7:0] gb_q;
    // block outputs lag the buffers by one cycle, so compare against last cycle's buffers
    always @(posedge i_ref_clk) begin
        gb_q <= o_global_buffer;
        if (i_sys_rst || !i_synth_reset_n || i_config_active) begin
            lock_age <= 12'h000;
        end else if (lock_age != 12'hFFF) begin
            lock_age <= lock_age + 12'h001;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_cfg_load;
        i_config_active;
    endsequence
    sequence s_cfg_end;
        $fell(i_config_active);
    endsequence
    a_hiz_cfg_held: assert property (s_cfg_load |=> o_global_high_impedance)
        else $error("pins left driven during configuration");
    a_greset_cfg_held: assert property (s_cfg_load |=> o_global_reset)
        else $error("fabric reset missing during configuration");
    a_cfg_release: assert property (s_cfg_end |=> !o_global_high_impedance && !o_global_reset)
        else $error("configuration controls stuck after load");
    a_rst_even_only: assert property ((o_blk_set_reset & ~{gb_q[6], gb_q[4], gb_q[2], gb_q[0]}) == 4'h0)
        else $error("set reset driven without its even buffer");
    a_ce_odd_only: assert property ((o_blk_clk_enable & ~{gb_q[7], gb_q[5], gb_q[3], gb_q[1]}) == 4'h0)
        else $error("clock enable driven without its odd buffer");
    a_blk_clk_src: assert property ((o_blk_clock & ~gb_q) == 8'h00)
        else $error("block clock high without its buffer");
    a_osc_pins_free: assert property (o_pin_gpio_free[5:4] == 2'h3 &&
        (o_global_buffer & o_pin_gpio_free & 8'hCF) == 8'h00)
        else $error("pins without a buffer marked in use");
    a_fabric_same: assert property (o_synth_out_fabric == o_synth_out_global_net)
        else $error("fabric and global synth outputs differ");
    a_lock_in_reset: assert property (!i_synth_reset_n |=> !o_synth_lock)
        else $error("lock shown while synth held in reset");
    a_lock_settle: assert property ($rose(o_synth_lock) |-> lock_age >= LOCK_MIN)
        else $error("lock before acquire time");
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus wait or error response");
endmodule // clk_net_monitor

bind global_clock_net_and_pll clk_net_monitor u_mon (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_config_active(i_config_active),
    .i_synth_reset_n(i_synth_reset_n),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_global_high_impedance(o_global_high_impedance),
    .o_global_reset(o_global_reset),
    .o_pin_gpio_free(o_pin_gpio_free),
    .o_synth_out_global_net(o_synth_out_global_net),
    .o_synth_out_fabric(o_synth_out_fabric),
    .o_synth_lock(o_synth_lock),
    .o_global_buffer(o_global_buffer),
    .o_blk_clock(o_blk_clock),
    .o_blk_set_reset(o_blk_set_reset),
    .o_blk_clk_enable(o_blk_clk_enable)
);

/* bench/clk_src_model.sv */
// model of the clock sources and the serial reprogramming master
`timescale 1ns/10ps
module clk_src_model (
    input wire i_ref_clk,
    input wire i_sys_rst,
    input wire i_ser_start,
    input wire [15:0] i_ser_word,
    output wire o_synth_ref_clock,
    output wire o_synth_external_fb,
    output wire o_low_freq_oscillator,
    output wire o_high_freq_oscillator,
    output wire o_reprogram_serial_clk,
    output wire o_reprogram_serial_in,
    output logic o_ser_busy
);
    logic [7:0] cnt;
    logic [5:0] ph;
    logic [15:0] word;
    // reference at a sixteenth of the system clock keeps it below the sys/4 limit
    assign o_synth_ref_clock = cnt[3];
    assign o_synth_external_fb = cnt[2];
    assign o_low_freq_oscillator = cnt[7];
    assign o_high_freq_oscillator = cnt[1];
    // serial clock stands low outside words; data changes only while it is low
    assign o_reprogram_serial_clk = o_ser_busy & ph[1];
    assign o_reprogram_serial_in = o_ser_busy ? word[~ph[5:2]] : ~word[0];
    always @(posedge i_ref_clk) begin
        cnt <= cnt + 8'h01;
        if (i_sys_rst) begin
            o_ser_busy <= 1'b0;
            ph <= 6'h00;
            word <= 16'h0000;
        end else if (o_ser_busy) begin
            ph <= ph + 6'h01;
            o_ser_busy <= (ph != 6'h3F);
        end else if (i_ser_start) begin
            o_ser_busy <= 1'b1;
            word <= i_ser_word;
        end
    end
    initial cnt = 8'h00;
endmodule // clk_src_model

/* bench/global_clock_net_and_pll_tb.sv */
// self-checking bench of the global clock network and synthesizer
`timescale 1ns/10ps
module global_clock_net_and_pll_tb;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_due = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic cfg = 1'b0, srst_n = 1'b0, hold = 1'b0, ser_go = 1'b0;
    logic [7:0] pins = 8'h00, fdel = 8'h00, usec;
    logic [15:0] ser_word = 16'h0000;
    wire hreadyout, hresp, hiz, greset, refc, extfb, lfo, hfo, sclk, reprogram_serial_in, sout_g, lock, ser_busy;
    wire [31:0] hrdata;
    wire [7:0] gpio_free, global_buffer, bclk;
    wire [3:0] bsr, bce, blut;
    wire [2:0] obs = {global_buffer[5], global_buffer[4], sout_g};
    logic [31:0] expq[$];
    int miscompares = 0, cmp_count = 0, cyc = 0, n, k;
    int seed = 32'hA4071FD7;
    global_clock_net_and_pll u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_config_active(cfg), .o_global_high_impedance(hiz),
        .o_global_reset(greset), .i_global_pin(pins), .i_low_freq_oscillator(lfo),
        .i_high_freq_oscillator(hfo), .o_pin_gpio_free(gpio_free), .i_synth_ref_clock(refc),
        .i_synth_external_fb(extfb), .i_synth_reset_n(srst_n), .i_fine_delay_setting(fdel),
        .i_low_power_hold(hold), .i_reprogram_serial_clk(sclk), .i_reprogram_serial_in(reprogram_serial_in),
        .o_synth_out_global_net(sout_g), .o_synth_out_fabric(), .o_synth_lock(lock),
        .o_global_buffer(global_buffer), .o_blk_clock(bclk), .o_blk_set_reset(bsr),
        .o_blk_clk_enable(bce), .o_blk_lut_in(blut));
    clk_src_model u_src (.i_ref_clk(clk), .i_sys_rst(rst), .i_ser_start(ser_go),
        .i_ser_word(ser_word), .o_synth_ref_clock(refc), .o_synth_external_fb(extfb),
        .o_low_freq_oscillator(lfo), .o_high_freq_oscillator(hfo),
        .o_reprogram_serial_clk(sclk), .o_reprogram_serial_in(reprogram_serial_in), .o_ser_busy(ser_busy));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic near(input int v, input int e);
        check(32'(v >= e - 1 && v <= e + 1), 32'h1);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one word transfer; a read leaves its expected word for the watcher
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, e);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rd_due <= !w;
        if (!w) expq.push_back(e);
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd_due <= 1'b0;
    endtask
    // counts rising levels of one observed output, sampled between edges
    task automatic rises(input int sel, input int cycles, output int cnt);
        logic p;
        cnt = 0;
        @(negedge clk);
        p = obs[sel];
        repeat (cycles) begin
            @(negedge clk);
            if (obs[sel] && !p) cnt++;
            p = obs[sel];
        end
    endtask
    // read data stands at the edge closing the data phase
    always @(posedge clk) begin
        if (rd_due) check(hrdata, expq.pop_front());
    end
    // cut a hang short; covers the lock wait with margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        srst_n <= 1'b1;
        ahb(8'h00, 1'b0, 32'h0, 32'h0);
        ahb(8'h04, 1'b0, 32'h0, 32'h1);
        ahb(8'h40, 1'b1, 32'hFFFFFFFF, 32'h0);
        ahb(8'h40, 1'b0, 32'h0, 32'h0);
        ahb(8'h08, 1'b1, 32'hFFFFFFA5, 32'h0);
        ahb(8'h08, 1'b0, 32'h0, 32'hA5);
        $display("register map test done");
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            usec = $random(seed);
            pins <= $random(seed);
            ahb(8'h0C, 1'b1, 32'h5555, 32'h0);
            ahb(8'h10, 1'b1, {8'h0F, 8'h0F, 8'h0F, usec}, 32'h0);
            repeat (4) @(negedge clk);
            check(32'({global_buffer[7:6], global_buffer[3:0]}), 32'({pins[7:6], pins[3:0]}));
            check(32'({bclk[7:6], bclk[3:0]}), 32'({pins[7:6], pins[3:0]} & {usec[7:6], usec[3:0]}));
            check(32'(blut), 32'(pins[3:0]));
            check(32'({bsr[3], bsr[1:0]}), 32'({pins[6], pins[2], pins[0]}));
            check(32'({bce[3], bce[1:0]}), 32'({pins[7], pins[3], pins[1]}));
            check(32'(gpio_free), 32'h30);
        end
        rises(1, 512, n);
        near(n, 2);
        rises(2, 64, n);
        near(n, 16);
        $display("buffer routing test done");
        @(posedge clk);
        cfg <= 1'b1;
        repeat (3) @(negedge clk);
        check(32'({hiz, greset}), 32'h3);
        @(posedge clk);
        cfg <= 1'b0;
        repeat (3) @(negedge clk);
        check(32'({hiz, greset}), 32'h0);
        check(32'(gpio_free), 32'hFF);
        ahb(8'h0C, 1'b0, 32'h0, 32'h0);
        $display("configuration test done");
        @(posedge clk);
        ser_word <= 16'h0002;
        ser_go <= 1'b1;
        @(posedge clk);
        ser_go <= 1'b0;
        @(posedge clk);
        while (ser_busy) @(posedge clk);
        ahb(8'h18, 1'b0, 32'h0, 32'h2);
        ahb(8'h04, 1'b0, 32'h0, 32'h2);
        ahb(8'h00, 1'b1, 32'h1, 32'h0);
        while (lock !== 1'b1) @(posedge clk);
        for (k = 0; k < 3; k++) begin
            ahb(8'h04, 1'b1, {21'h0, 3'(k * 3), 8'h02}, 32'h0);
            rises(0, 1024, n);
            near(n, 128 >> (k * 3));
        end
        ahb(8'h0C, 1'b1, 32'hA00, 32'h0);
        rises(1, 1024, n);
        near(n, 2);
        @(posedge clk);
        fdel <= 8'h40;
        repeat (8) @(negedge clk);
        check(32'(lock), 32'h1);
        ahb(8'h00, 1'b1, 32'h9, 32'h0);
        fdel <= 8'h41;
        repeat (3) @(negedge clk);
        check(32'(lock), 32'h0);
        @(posedge clk);
        srst_n <= 1'b0;
        rises(0, 256, n);
        check(32'({lock, 31'(n)}), 32'h0);
        @(posedge clk);
        srst_n <= 1'b1;
        ahb(8'h04, 1'b1, 32'h2, 32'h0);
        ahb(8'h00, 1'b1, 32'h5, 32'h0);
        repeat (1400) @(negedge clk);
        check(32'(lock), 32'h1);
        $display("synthesizer test done");
        @(posedge clk);
        hold <= 1'b1;
        ahb(8'h00, 1'b1, 32'h1, 32'h0);
        rises(0, 256, n);
        check(32'(n > 0), 32'h1);
        ahb(8'h00, 1'b1, 32'h31, 32'h0);
        rises(0, 256, n);
        check(32'(n), 32'h0);
        @(posedge clk);
        hold <= 1'b0;
        ahb(8'h00, 1'b1, 32'h2, 32'h0);
        rises(0, 256, n);
        near(n, 16);
        $display("hold and bypass test done");
        complete_run();
    end
endmodule // global_clock_net_and_pll_tb

/* hw/clk_ctrl_map.vh */
// register map, field positions, reset values and timing counts of the clock controller
`ifndef CLK_CTRL_MAP_VH
`define CLK_CTRL_MAP_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_DIVIDE 8'h04
`define REG_DELAY 8'h08
`define REG_GLOBAL_BUFFER_SRC 8'h0C
`define REG_GLOBAL_BUFFER_USE 8'h10
`define REG_STATUS 8'h14
`define REG_SERIAL 8'h18

// control register fields
`define CTRL_SYNTH_RUN 0
`define CTRL_BYPASS 1
`define CTRL_FB_EXTERNAL 2
`define CTRL_DELAY_DYNAMIC 3
`define CTRL_GATE_A 4
`define CTRL_GATE_B 5
`define CTRL_RESET 6'h00

// divider register fields and reset value
`define DIV_FB_LSB 0
`define DIV_FB_MSB 6
`define DIV_OUT_LSB 8
`define DIV_OUT_MSB 10
`define DIV_OUT_MAX 3'h6
`define DIVIDE_RESET 11'h001

// buffer source codes, two bits per buffer
`define SRC_OFF 2'h0
`define SRC_DIRECT 2'h1
`define SRC_SYNTH 2'h2

// buffer use register fields
`define USE_CLK_LSB 0
`define USE_LUT_LSB 8
`define USE_RST_LSB 16
`define USE_CE_LSB 24

// synthesizer loop constants
`define NCO_INC_RESET 16'h0100
`define NCO_STEP 16'h0040
`define NCO_INC_MAX 16'h7FC0
`define SERIAL_WORD_BITS 5'h10
`define SYS_CLK_NS 40
`define LOCK_ACQUIRE_NS 50000
`define LOCK_ACQUIRE_CYC ((`LOCK_ACQUIRE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

/* hw/global_clock_net_and_pll.v */
// global clock/control network and frequency synthesizer with an ahb-lite register port
`timescale 1ns/10ps
`include "clk_ctrl_map.vh"

module global_clock_net_and_pll (
    input wire i_ref_clk,
    input wire i_sys_rst,
    // ahb-lite slave
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output wire o_hreadyout,
    output wire o_hresp,
    output reg [31:0] o_hrdata,
    // configuration sequencing
    input wire i_config_active,
    output reg o_global_high_impedance,
    output reg o_global_reset,
    // clock sources
    input wire [7:0] i_global_pin,
    input wire i_low_freq_oscillator,
    input wire i_high_freq_oscillator,
    output reg [7:0] o_pin_gpio_free,
    // synthesizer ports
    input wire i_synth_ref_clock,
    input wire i_synth_external_fb,
    input wire i_synth_reset_n,
    input wire [7:0] i_fine_delay_setting,
    input wire i_low_power_hold,
    input wire i_reprogram_serial_clk,
    input wire i_reprogram_serial_in,
    output reg o_synth_out_global_net,
    output reg o_synth_out_fabric,
    output reg o_synth_lock,
    // global buffers and logic block connections
    output reg [7:0] o_global_buffer,
    output reg [7:0] o_blk_clock,
    output reg [3:0] o_blk_set_reset,
    output reg [3:0] o_blk_clk_enable,
    output reg [3:0] o_blk_lut_in
);

    localparam integer LOCK_CYC_INT = `LOCK_ACQUIRE_CYC;
    localparam [11:0] LOCK_CYCLES = LOCK_CYC_INT[11:0];
    // registers seen by software
    reg [5:0] ctrl;
    reg [10:0] divide;
    reg [7:0] delay_static;
    reg [15:0] global_buffer_src;
    reg [31:0] global_buffer_use;
    reg [15:0] serial_word;

    // synthesizer state
    reg [15:0] phase;
    reg [15:0] nco_inc;
    reg synth_prev;
    reg [5:0] div_cnt;
    reg ref_prev;
    reg fb_prev;
    reg [7:0] fb_cnt;
    reg [7:0] fb_last;
    reg [11:0] lock_timer;
    reg err_zero;
    reg [7:0] delay_prev;

    // serial reprogramming state
    reg sclk_prev;
    reg [15:0] serial_shift;
    reg [4:0] serial_bits;

    // bus data phase state
    reg wr_pend;
    reg [7:0] wr_addr;

    // configuration forces every flop except the bus port and configuration outputs to its wake-up value
    wire any_rst = i_sys_rst | i_config_active;

    // ------------------------------------------------------------------
    // ahb-lite slave: zero wait state, always okay
    // ------------------------------------------------------------------
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    wire addr_phase = i_hsel & i_htrans[1] & i_hready;
    wire wr_hit = wr_pend;

    // capture the address phase of a write for use in the data phase
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_phase & i_hwrite;
            wr_addr <= i_haddr[7:0];
        end
    end

    // read data is muxed in the address phase so it stands in the data phase
    reg [31:0] next_rdata;
    wire synth_in_reset;
    wire hold_active;
    always @* begin
        next_rdata = 32'h00000000;
        case (i_haddr[7:0])
            `REG_CTRL: next_rdata = {26'h0000000, ctrl};
            `REG_DIVIDE: next_rdata = {21'h000000, divide};
            `REG_DELAY: next_rdata = {24'h000000, delay_static};
            `REG_GLOBAL_BUFFER_SRC: next_rdata = {16'h0000, global_buffer_src};
            `REG_GLOBAL_BUFFER_USE: next_rdata = global_buffer_use;
            `REG_STATUS: next_rdata = {nco_inc, fb_last, 4'h0, hold_active,
                                       synth_in_reset, i_config_active, o_synth_lock};
            `REG_SERIAL: next_rdata = {16'h0000, serial_word};
            default: next_rdata = 32'h00000000; // unmapped reads as zero
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_hrdata <= 32'h00000000;
        end else if (addr_phase & ~i_hwrite) begin
            o_hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // serial reprogramming port: shift on each rising serial clock
    // ------------------------------------------------------------------
    wire sclk_rise = i_reprogram_serial_clk & ~sclk_prev;
    wire serial_done = sclk_rise & (serial_bits == `SERIAL_WORD_BITS - 5'h01);

    always @(posedge i_ref_clk) begin
        if (any_rst) begin
            sclk_prev <= 1'b0;
            serial_shift <= 16'h0000;
            serial_bits <= 5'h00;
            serial_word <= 16'h0000;
        end else begin
            sclk_prev <= i_reprogram_serial_clk;
            if (sclk_rise) begin
                serial_shift <= {serial_shift[14:0], i_reprogram_serial_in};
                serial_bits <= serial_done ? 5'h00 : serial_bits + 5'h01;
            end
            if (serial_done) begin
                serial_word <= {serial_shift[14:0], i_reprogram_serial_in};
            end
        end
    end

    // ------------------------------------------------------------------
    // register writes; a finished serial word wins over a bus write
    // ------------------------------------------------------------------
    wire [15:0] serial_full = {serial_shift[14:0], i_reprogram_serial_in};

    always @(posedge i_ref_clk) begin
        if (any_rst) begin
            ctrl <= `CTRL_RESET;
            divide <= `DIVIDE_RESET;
            delay_static <= 8'h00;
            global_buffer_src <= 16'h0000;
            global_buffer_use <= 32'h00000000;
        end else begin
            if (wr_hit) begin
                case (wr_addr)
                    `REG_CTRL: ctrl <= i_hwdata[5:0];
                    `REG_DIVIDE: divide <= i_hwdata[10:0];
                    `REG_DELAY: delay_static <= i_hwdata[7:0];
                    `REG_GLOBAL_BUFFER_SRC: global_buffer_src <= i_hwdata[15:0];
                    `REG_GLOBAL_BUFFER_USE: global_buffer_use <= i_hwdata;
                    default: ; // read-only or unmapped: ignored
                endcase
            end
            if (serial_done) begin
                divide <= serial_full[10:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // synthesizer: digital frequency loop on an nco
    // ------------------------------------------------------------------
    wire [6:0] fb_div = divide[`DIV_FB_MSB:`DIV_FB_LSB];
    wire [2:0] out_div = (divide[`DIV_OUT_MSB:`DIV_OUT_LSB] > `DIV_OUT_MAX) ?
                         `DIV_OUT_MAX : divide[`DIV_OUT_MSB:`DIV_OUT_LSB];

    assign synth_in_reset = ~i_synth_reset_n | ~ctrl[`CTRL_SYNTH_RUN];
    // hold needs the input and both gating options
    assign hold_active = i_low_power_hold & ctrl[`CTRL_GATE_A] & ctrl[`CTRL_GATE_B];

    // the fine delay pins are ignored unless dynamic mode is chosen
    wire [7:0] delay_eff = ctrl[`CTRL_DELAY_DYNAMIC] ? i_fine_delay_setting
                                                     : delay_static;
    // delay is a phase offset, one step = 1/256 of a period
    wire [15:0] shifted = phase + {delay_eff, 8'h00};
    wire synth_raw = shifted[15];
    wire synth_rise = synth_raw & ~synth_prev;

    // output divider by 2^n, n = 0..6
    reg divided;
    always @* begin
        case (out_div)
            3'h0: divided = synth_raw;
            3'h1: divided = div_cnt[0];
            3'h2: divided = div_cnt[1];
            3'h3: divided = div_cnt[2];
            3'h4: divided = div_cnt[3];
            3'h5: divided = div_cnt[4];
            default: divided = div_cnt[5];
        endcase
    end

    // feedback edges: the external pin is watched only when selected
    wire fb_src = ctrl[`CTRL_FB_EXTERNAL] ? i_synth_external_fb : synth_raw;
    wire fb_rise = fb_src & ~fb_prev;
    wire ref_rise = i_synth_ref_clock & ~ref_prev;
    wire fb_slow = ({1'b0, fb_cnt} < {2'b00, fb_div});
    wire fb_fast = ({1'b0, fb_cnt} > {2'b00, fb_div});
    // a dynamic shift disturbs the feedback output, forcing a relock
    wire delay_moved = ctrl[`CTRL_DELAY_DYNAMIC] & (delay_eff != delay_prev);

    // nco, output divider and edge history; frozen while holding
    always @(posedge i_ref_clk) begin
        if (any_rst | synth_in_reset) begin
            phase <= 16'h0000;
            synth_prev <= 1'b0;
            div_cnt <= 6'h00;
        end else if (!hold_active) begin
            phase <= phase + nco_inc;
            synth_prev <= synth_raw;
            if (synth_rise) begin
                div_cnt <= div_cnt + 6'h01;
            end
        end
    end

    // once per reference period step the nco toward fb_div edges; a coarse step keeps acquiry short
    always @(posedge i_ref_clk) begin
        if (any_rst | synth_in_reset) begin
            nco_inc <= `NCO_INC_RESET;
            ref_prev <= 1'b0;
            fb_prev <= 1'b0;
            fb_cnt <= 8'h00;
            fb_last <= 8'h00;
            err_zero <= 1'b0;
        end else begin
            ref_prev <= i_synth_ref_clock;
            fb_prev <= fb_src;
            if (ref_rise) begin
                fb_last <= fb_cnt;
                fb_cnt <= fb_rise ? 8'h01 : 8'h00;
                err_zero <= ~fb_slow & ~fb_fast;
                if (fb_slow && nco_inc < `NCO_INC_MAX) begin
                    nco_inc <= nco_inc + `NCO_STEP;
                end else if (fb_fast && nco_inc > `NCO_STEP) begin
                    nco_inc <= nco_inc - `NCO_STEP;
                end
            end else if (fb_rise && fb_cnt != 8'hFF) begin
                fb_cnt <= fb_cnt + 8'h01;
            end
        end
    end

    // lock: a clean period streak lasting the acquire time; any error drops it
    always @(posedge i_ref_clk) begin
        if (any_rst | synth_in_reset) begin
            lock_timer <= 12'h000;
            delay_prev <= 8'h00;
            o_synth_lock <= 1'b0;
        end else begin
            delay_prev <= delay_eff;
            if ((ref_rise && (fb_slow || fb_fast)) || delay_moved) begin
                lock_timer <= 12'h000;
                o_synth_lock <= 1'b0;
            end else if (err_zero && lock_timer != LOCK_CYCLES) begin
                lock_timer <= lock_timer + 12'h001;
            end else if (err_zero) begin
                o_synth_lock <= 1'b1;
            end
        end
    end

    // output select; bypass passes the reference straight through
    wire next_synth_out = ctrl[`CTRL_BYPASS] ? i_synth_ref_clock : divided;

    // both outputs share one next value, so their frequency is identical
    always @(posedge i_ref_clk) begin
        if (any_rst | (synth_in_reset & ~ctrl[`CTRL_BYPASS])) begin
            o_synth_out_global_net <= 1'b0;
            o_synth_out_fabric <= 1'b0;
        end else if (!hold_active) begin
            o_synth_out_global_net <= next_synth_out;
            o_synth_out_fabric <= next_synth_out;
        end
    end

    // ------------------------------------------------------------------
    // global buffers: one source select per buffer
    // ------------------------------------------------------------------
    wire [7:0] next_global_buffer;
    wire [7:0] pin_taken;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_buf
            wire [1:0] sel = global_buffer_src[2 * gi + 1:2 * gi];
            if (gi == 4 || gi == 5) begin : g_osc
                // oscillator direct, or the synth global net preferred here
                wire osc = (gi == 4) ? i_low_freq_oscillator : i_high_freq_oscillator;
                assign next_global_buffer[gi] = (sel == `SRC_DIRECT) ? osc :
                                       (sel == `SRC_SYNTH) ? o_synth_out_global_net :
                                       1'b0;
                assign pin_taken[gi] = 1'b0;
            end else begin : g_pin
                assign next_global_buffer[gi] = (sel == `SRC_DIRECT) & i_global_pin[gi];
                assign pin_taken[gi] = (sel == `SRC_DIRECT);
            end
        end
    endgenerate

    // pick the first four buffers enabled for lookup inputs
    reg [3:0] next_lut;
    reg [2:0] lut_used;
    integer li;
    always @* begin
        next_lut = 4'h0;
        lut_used = 3'h0;
        for (li = 0; li < 8; li = li + 1) begin
            if (global_buffer_use[`USE_LUT_LSB + li] && lut_used < 3'h4) begin
                next_lut[lut_used[1:0]] = o_global_buffer[li];
                lut_used = lut_used + 3'h1;
            end
        end
    end

    // buffer and block connections are registered for clean data outputs
    integer bi;
    always @(posedge i_ref_clk) begin
        if (any_rst) begin
            o_global_buffer <= 8'h00;
            o_blk_clock <= 8'h00;
            o_blk_set_reset <= 4'h0;
            o_blk_clk_enable <= 4'h0;
            o_blk_lut_in <= 4'h0;
            o_pin_gpio_free <= 8'hFF;
        end else begin
            o_global_buffer <= next_global_buffer;
            o_blk_clock <= o_global_buffer & global_buffer_use[`USE_CLK_LSB + 7:`USE_CLK_LSB];
            o_blk_lut_in <= next_lut;
            o_pin_gpio_free <= ~pin_taken;
            for (bi = 0; bi < 4; bi = bi + 1) begin
                // set/reset only from even, enable only from odd buffers
                o_blk_set_reset[bi] <= o_global_buffer[2 * bi] &
                                       global_buffer_use[`USE_RST_LSB + bi];
                o_blk_clk_enable[bi] <= o_global_buffer[2 * bi + 1] &
                                        global_buffer_use[`USE_CE_LSB + bi];
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration: high impedance and global reset follow the load
    // ------------------------------------------------------------------
    // reset value is asserted so pins stay safe until the first sample
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_global_high_impedance <= 1'b1;
            o_global_reset <= 1'b1;
        end else begin
            o_global_high_impedance <= i_config_active;
            o_global_reset <= i_config_active;
        end
    end

endmodule // global_clock_net_and_pll
